// ===== design/scc_ctrl_status.sv
// The implementer's own choices: the register offsets and strobed register access.
`timescale 1ns/1ps
module scc_ctrl_status (
	input wire logic core_clk_i,
	input wire logic resetn_i,
	input wire logic standby_i,
	input wire logic [2:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	input wire logic dma_tx_wr_i,
	input wire logic [7:0] dma_tx_data_i,
	input wire logic dma_rx_rd_i,
	input wire logic [7:0] baud_div_i,
	input wire logic rxd_i,
	output logic txd_o,
	input wire logic sclk_i,
	output logic sclk_o,
	output logic sclk_oe_o,
	output logic txempty_irq_o,
	output logic rxfull_irq_o,
	output logic rxerr_irq_o,
	output logic txdone_irq_o
);
	import scc_pkg::*;
	typedef enum logic [1:0] {
		SCC_IDLE = 2'b00,
		SCC_START = 2'b01,
		SCC_DATA = 2'b11,
		SCC_STOP = 2'b10
	} scc_state_t;

	logic [7:0] frame_cfg_reg;
	logic [7:0] ctrl_reg;
	logic [7:0] flags_reg;
	logic [7:0] tx_hold_reg;
	logic [7:0] rx_hold_reg;
	logic [7:0] seen_one;
	logic init;
	logic pre_tick;
	logic [7:0] baud_cnt;
	logic bit_tick;
	logic sync_mode;
	logic mp_fmt;
	logic ext_clk;
	logic sclk_q;
	logic sclk_prev;
	logic sclk_rise;
	logic samp_tick;
	logic flags_wr;
	logic txd_wr;
	scc_state_t tx_state;
	logic [9:0] tx_shift_reg;
	logic [3:0] tx_bits;
	logic [3:0] tx_ovs;
	logic tx_stop2;
	logic tx_load;
	logic tx_last;
	scc_state_t rx_state;
	logic [8:0] rx_shift_reg;
	logic [3:0] rx_bits;
	logic [3:0] rx_ovs;
	logic rx_end;
	logic rx_stop_ok;
	logic rx_par_ok;
	logic rx_mpb;
	logic addr_wait;
	logic rx_hold_err;
	logic [3:0] data_bits;
	logic next_tx_ovs_wrap;
	logic tx_bit_adv;
	logic [3:0] rx_nbits;
	logic [8:0] rx_aligned;

	assign init = standby_i;
	assign sync_mode = frame_cfg_reg[F_SYNC]; // R26
	assign mp_fmt = frame_cfg_reg[F_MP] & ~sync_mode; // R3
	assign addr_wait = ctrl_reg[C_ADDR_WAIT_GATE] & mp_fmt; // R15
	assign ext_clk = ctrl_reg[C_CKE1]; // R17
	assign data_bits = (frame_cfg_reg[F_CHR] & ~sync_mode) ?
		SCC_CNT_DATA7 : SCC_CNT_DATA8;
	assign flags_wr = wr_i & (addr_i == SCC_ADDR_FLAGS);
	assign txd_wr = wr_i & (addr_i == SCC_ADDR_TXD);
	// errors stall reception until software clears them
	assign rx_hold_err = flags_reg[S_OVERRUN_FLAG] | flags_reg[S_FER] |
		flags_reg[S_PER];

	scc_prescale u_pre (
		.core_clk_i(core_clk_i),
		.resetn_i(resetn_i),
		.prescale_sel_i(frame_cfg_reg[1:0]),
		.tick_o(pre_tick)
	);

	// bit-rate base counter; async internal runs 16 ticks per bit
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			baud_cnt <= SCC_BAUD_DEF;
		end else if (pre_tick) begin
			baud_cnt <= (baud_cnt == 8'h00) ? baud_div_i : baud_cnt - 8'h01;
		end
	end
	assign bit_tick = pre_tick & (baud_cnt == 8'h00);

	// external clock: sampled as a synchronous level, edge detected
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			// idle-high level, so no false edge follows reset
			sclk_q <= 1'b1;
			sclk_prev <= 1'b1;
		end else begin
			sclk_q <= sclk_i;
			sclk_prev <= sclk_q;
		end
	end
	assign sclk_rise = sclk_q & ~sclk_prev;
	assign samp_tick = ext_clk ? sclk_rise : bit_tick; // R17

	// R18
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			sclk_o <= 1'b1;
		end else if (samp_tick && !ext_clk &&
			tx_ovs[2:0] == SCC_OVS_MID[2:0]) begin
			// two toggles per sixteen ticks give one period per async bit; sync bits advance every tick
			sclk_o <= ~sclk_o;
		end
	end
	assign sclk_oe_o = ~ext_clk & (sync_mode | ctrl_reg[C_CKE0]); // R17 R18

	// R5
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			frame_cfg_reg <= SCC_FMT_RST;
		end else if (init) begin
			frame_cfg_reg <= SCC_FMT_RST;
		end else if (wr_i && addr_i == SCC_ADDR_FMT) begin
			frame_cfg_reg <= wdata_i;
		end
	end

	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ctrl_reg <= SCC_CTRL_RST; // R5
		end else if (init) begin
			ctrl_reg <= SCC_CTRL_RST; // R5
		end else begin
			if (wr_i && addr_i == SCC_ADDR_CTRL) begin
				ctrl_reg <= wdata_i;
			end
			if (rx_end && addr_wait && rx_mpb) begin
				ctrl_reg[C_ADDR_WAIT_GATE] <= 1'b0; // R14
			end
		end
	end

	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			tx_hold_reg <= SCC_TXD_RST;
		end else if (init) begin
			tx_hold_reg <= SCC_TXD_RST;
		end else if (dma_tx_wr_i) begin
			tx_hold_reg <= dma_tx_data_i;
		end else if (txd_wr) begin
			tx_hold_reg <= wdata_i;
		end
	end

	// read-1 tracking per clearable flag
	for (genvar i = 0; i < 8; i++) begin : g_seen
		always_ff @(posedge core_clk_i or negedge resetn_i) begin
			if (!resetn_i) begin
				seen_one[i] <= 1'b0;
			end else if (init || !flags_reg[i] ||
				(flags_wr && !wdata_i[i])) begin
				// a flag that dropped must be read as 1 again
				seen_one[i] <= 1'b0;
			end else if (rd_i && addr_i == SCC_ADDR_FLAGS && flags_reg[i]) begin
				seen_one[i] <= 1'b1; // R19
			end
		end
	end

	// transmitter: load once data is waiting and buffer flag cleared
	assign tx_load = (tx_state == SCC_IDLE) & ctrl_reg[C_TE] &
		~flags_reg[S_TX_BUF_EMPTY] & ~(sync_mode & rx_hold_err); // R9
	// external async clock runs sixteen ticks per bit as well
	assign next_tx_ovs_wrap = sync_mode ? 1'b1 :
		(tx_ovs == SCC_OVS_LAST); // R17
	assign tx_bit_adv = samp_tick & next_tx_ovs_wrap;
	assign tx_last = tx_bit_adv & (tx_state == SCC_STOP) &
		(tx_stop2 | sync_mode | ~frame_cfg_reg[F_STOP]);

	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			tx_state <= SCC_IDLE;
			tx_shift_reg <= '1;
			tx_bits <= '0;
			tx_ovs <= '0;
			tx_stop2 <= 1'b0;
			txd_o <= 1'b1;
		end else if (init || !ctrl_reg[C_TE]) begin
			tx_state <= SCC_IDLE;
			tx_ovs <= '0;
			txd_o <= 1'b1;
		end else begin
			if (samp_tick) begin
				tx_ovs <= tx_ovs + 4'h1;
			end
			case (tx_state)
				SCC_IDLE: begin
					if (tx_load) begin
						// parity or address bit rides above the data
						tx_shift_reg <= {1'b1, mp_fmt ? flags_reg[S_MPBT] :
							(^tx_hold_reg) ^ frame_cfg_reg[F_ODD], tx_hold_reg};
						if (data_bits == SCC_CNT_DATA7) begin
							tx_shift_reg[7] <= mp_fmt ? flags_reg[S_MPBT] :
								(^tx_hold_reg[6:0]) ^ frame_cfg_reg[F_ODD];
						end
						tx_state <= sync_mode ? SCC_DATA : SCC_START;
						tx_bits <= '0;
						tx_ovs <= '0;
						tx_stop2 <= 1'b0;
						txd_o <= sync_mode ? tx_hold_reg[0] : 1'b0;
					end
				end
				SCC_START: begin
					if (tx_bit_adv) begin
						tx_state <= SCC_DATA;
						txd_o <= tx_shift_reg[0];
					end
				end
				SCC_DATA: begin
					if (tx_bit_adv) begin
						tx_shift_reg <= {1'b1, tx_shift_reg[9:1]};
						tx_bits <= tx_bits + 4'h1;
						// R3
						if (tx_bits == data_bits - 4'h1 +
							{3'h0, ~sync_mode & (mp_fmt | frame_cfg_reg[F_PE])}) begin
							tx_state <= SCC_STOP;
							txd_o <= 1'b1; // R1
						end else begin
							txd_o <= tx_shift_reg[1];
						end
					end
				end
				SCC_STOP: begin
					if (tx_last) begin
						tx_state <= SCC_IDLE;
					end else if (tx_bit_adv) begin
						tx_stop2 <= 1'b1; // R1
					end
				end
				default: tx_state <= SCC_IDLE;
			endcase
		end
	end

	// receiver
	assign rx_stop_ok = rxd_i;
	// frame bits enter at the top; shift the frame down to bit 0
	assign rx_nbits = data_bits +
		{3'h0, ~sync_mode & (mp_fmt | frame_cfg_reg[F_PE])};
	assign rx_aligned = rx_shift_reg >> (SCC_CNT_DATA8 + 4'h1 - rx_nbits);
	assign rx_mpb = rx_aligned[data_bits];
	assign rx_par_ok = ~frame_cfg_reg[F_PE] | mp_fmt |
		((^rx_shift_reg) == frame_cfg_reg[F_ODD]);
	// first stop bit sampled in its middle, like the data bits
	assign rx_end = (rx_state == SCC_STOP) & samp_tick &
		(sync_mode | rx_ovs == SCC_OVS_LAST); // R17

	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rx_state <= SCC_IDLE;
			rx_shift_reg <= '0;
			rx_bits <= '0;
			rx_ovs <= '0;
		end else if (init || !ctrl_reg[C_RE] || rx_hold_err) begin
			rx_state <= SCC_IDLE;
			rx_ovs <= '0;
		end else begin
			if (samp_tick) begin
				rx_ovs <= rx_ovs + 4'h1;
			end
			case (rx_state)
				SCC_IDLE: begin
					// R12 R2
					if (sync_mode ? samp_tick : !rxd_i) begin
						rx_state <= sync_mode ? SCC_DATA : SCC_START;
						rx_ovs <= '0;
						rx_bits <= '0;
						rx_shift_reg <= '0;
						if (sync_mode) begin
							rx_shift_reg <= {rxd_i, 8'h00};
							rx_bits <= 4'h1;
						end
					end
				end
				SCC_START: begin
					if (samp_tick && rx_ovs == SCC_OVS_MID) begin
						rx_state <= rxd_i ? SCC_IDLE : SCC_DATA;
						rx_ovs <= '0;
					end
				end
				SCC_DATA: begin
					if (samp_tick &&
						(sync_mode || rx_ovs == SCC_OVS_LAST)) begin
						rx_shift_reg <= {rxd_i, rx_shift_reg[8:1]};
						rx_bits <= rx_bits + 4'h1;
						if (rx_bits == data_bits - 4'h1 +
							{3'h0, ~sync_mode & (mp_fmt | frame_cfg_reg[F_PE])}) begin
							rx_state <= SCC_STOP;
						end
					end
				end
				SCC_STOP: begin
					// only first stop bit is sampled
					if (rx_end) begin
						rx_state <= SCC_IDLE; // R2
					end
				end
				default: rx_state <= SCC_IDLE;
			endcase
		end
	end

	// receive holding register untouched by overrun; framing and parity error frames still load it
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rx_hold_reg <= SCC_RXD_RST;
		end else if (init) begin
			rx_hold_reg <= SCC_RXD_RST;
		end else if (rx_end && !flags_reg[S_RX_BUF_FULL] &&
			!(addr_wait && !rx_mpb)) begin // R13 R23
			// 7-bit frames leave their parity or address bit out
			rx_hold_reg <= rx_aligned[7:0] &
				{data_bits != SCC_CNT_DATA7, 7'h7f};
		end
	end

	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			flags_reg <= SCC_FLAGS_RST; // R20
		end else if (init) begin
			flags_reg <= SCC_FLAGS_RST; // R20
		end else begin
			// clears first, hardware sets below win
			if (flags_wr) begin
				for (int b = S_PER; b <= S_TX_BUF_EMPTY; b++) begin
					if (!wdata_i[b] && seen_one[b]) begin
						flags_reg[b] <= 1'b0; // R19
					end
				end
				flags_reg[S_MPBT] <= wdata_i[S_MPBT];
				if (!wdata_i[S_TX_BUF_EMPTY] && seen_one[S_TX_BUF_EMPTY]) begin
					flags_reg[S_TX_DONE_FLAG] <= 1'b0; // R16
				end
			end
			if (dma_tx_wr_i) begin
				flags_reg[S_TX_BUF_EMPTY] <= 1'b0; // R21
				flags_reg[S_TX_DONE_FLAG] <= 1'b0;
			end
			if (dma_rx_rd_i) begin
				flags_reg[S_RX_BUF_FULL] <= 1'b0; // R22
			end
			if (tx_load) begin
				flags_reg[S_TX_BUF_EMPTY] <= 1'b1; // R21
			end
			if (tx_last && flags_reg[S_TX_BUF_EMPTY] && !tx_load) begin
				flags_reg[S_TX_DONE_FLAG] <= 1'b1; // R25
			end
			if (!ctrl_reg[C_TE]) begin
				flags_reg[S_TX_BUF_EMPTY] <= 1'b1; // R8 R21
				flags_reg[S_TX_DONE_FLAG] <= 1'b1; // R25
			end
			// R11: nothing here looks at rx_enable
			if (rx_end && !(addr_wait && !rx_mpb)) begin // R13
				if (mp_fmt) begin
					flags_reg[S_MPB] <= rx_mpb; // R14
				end
				if (flags_reg[S_RX_BUF_FULL]) begin
					flags_reg[S_OVERRUN_FLAG] <= 1'b1; // R23
				end else if (!sync_mode && !rx_stop_ok) begin
					flags_reg[S_FER] <= 1'b1; // R24
				end else if (!sync_mode && !rx_par_ok) begin
					flags_reg[S_PER] <= 1'b1;
				end else begin
					flags_reg[S_RX_BUF_FULL] <= 1'b1; // R22
				end
			end
		end
	end

	// R6 R7 R16
	assign txempty_irq_o = flags_reg[S_TX_BUF_EMPTY] & ctrl_reg[C_TIE];
	assign rxfull_irq_o = flags_reg[S_RX_BUF_FULL] & ctrl_reg[C_RIE];
	assign rxerr_irq_o = rx_hold_err & ctrl_reg[C_RIE];
	assign txdone_irq_o = flags_reg[S_TX_DONE_FLAG] & ctrl_reg[C_TXDONE_IRQ_EN];

	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rdata_o <= '0;
		end else if (rd_i) begin
			case (addr_i)
				SCC_ADDR_FMT: rdata_o <= frame_cfg_reg;
				SCC_ADDR_CTRL: rdata_o <= ctrl_reg;
				SCC_ADDR_TXD: rdata_o <= tx_hold_reg;
				SCC_ADDR_FLAGS: rdata_o <= flags_reg;
				SCC_ADDR_RXD: rdata_o <= rx_hold_reg;
				default: rdata_o <= '0;
			endcase
		end else begin
			rdata_o <= '0;
		end
	end

	property p_tx_locked;
		@(posedge core_clk_i) disable iff (!resetn_i)
		!ctrl_reg[C_TE] |=> flags_reg[S_TX_BUF_EMPTY] && flags_reg[S_TX_DONE_FLAG];
	endproperty
	a_tx_locked: assert property (p_tx_locked) // R8
		else $error("tx empty not held while tx disabled");

	property p_no_set_by_write;
		@(posedge core_clk_i) disable iff (!resetn_i)
		flags_wr && !flags_reg[S_OVERRUN_FLAG] && !rx_end |=> !flags_reg[S_OVERRUN_FLAG];
	endproperty
	a_no_set_by_write: assert property (p_no_set_by_write) // R19
		else $error("status write set overrun");

	property p_txirq;
		@(posedge core_clk_i) disable iff (!resetn_i)
		txempty_irq_o && flags_wr && !wdata_i[S_TX_BUF_EMPTY] &&
			seen_one[S_TX_BUF_EMPTY] && ctrl_reg[C_TE] && !init |=>
			!txempty_irq_o;
	endproperty
	a_txirq: assert property (p_txirq) // R6
		else $error("tx empty irq mismatch");

	property p_rxerr_irq;
		@(posedge core_clk_i) disable iff (!resetn_i)
		!ctrl_reg[C_RIE] |-> !rxerr_irq_o && !rxfull_irq_o;
	endproperty
	a_rxerr_irq: assert property (p_rxerr_irq) // R7
		else $error("rx irq while disabled");

	sequence s_addr_frame;
		rx_end && addr_wait && rx_mpb;
	endsequence
	property p_addr_clear;
		@(posedge core_clk_i) disable iff (!resetn_i)
		(s_addr_frame and !init) |=>
			!ctrl_reg[C_ADDR_WAIT_GATE] && flags_reg[S_MPB];
	endproperty
	a_addr_clear: assert property (p_addr_clear) // R14
		else $error("address frame did not clear wait gate");

	property p_overrun;
		@(posedge core_clk_i) disable iff (!resetn_i)
		rx_end && flags_reg[S_RX_BUF_FULL] && !addr_wait && !init |=>
			flags_reg[S_OVERRUN_FLAG] && $stable(rx_hold_reg);
	endproperty
	a_overrun: assert property (p_overrun) // R23
		else $error("overrun not flagged");

	property p_wait_blocks;
		@(posedge core_clk_i) disable iff (!resetn_i)
		rx_end && addr_wait && !rx_mpb && !flags_wr && !dma_rx_rd_i |=>
			$stable(flags_reg[S_RX_BUF_FULL]) && $stable(rx_hold_reg);
	endproperty
	a_wait_blocks: assert property (p_wait_blocks) // R13
		else $error("data frame passed during address wait");

	property p_sclk_oe;
		@(posedge core_clk_i) disable iff (!resetn_i)
		sync_mode && !ext_clk |-> sclk_oe_o;
	endproperty
	a_sclk_oe: assert property (p_sclk_oe) // R18
		else $error("sync internal clock not driven");
endmodule

// ===== design/scc_pkg.sv
// Overview of operation
// R1: transmitter appends one or two high stop bits per stop-length bit.
// R2: receiver checks only first stop bit; low second bit starts next frame.
// R3: multi-node format overrides parity in async; ignored in sync mode.
// R4: prescale select feeds baud generator with clk, /4, /16 or /64.
// R5: control register always read/write, cleared by reset and standby.
// R6: tx-empty irq while tx_buf_empty and enable bit 7; cleared either way.
// R7: bit 6 gates rx-full and rx-error irqs; flag or enable clear removes.
// R8: while tx_enable is 0 the tx_buf_empty flag is held at 1.
// R9: transmission starts after holding write and tx_buf_empty cleared.
// R10: software programs frame format before enabling tx or rx.
// R11: clearing rx_enable leaves rx-full and error flags unchanged.
// R12: receiver starts on start bit (async) or incoming clock (sync).
// R13: address wait blocks transfer, flags and rx irqs until address frame.
// R14: address frame sets rx_addr_bit and clears address-wait gate.
// R15: address wait only works in async mode with multi-node format.
// R16: tx-done irq when no new data at last bit; cleared via flag or enable.
// R17: clock select 0x internal, 1x external; 01 async outputs bit clock.
// R18: low select bit matters only async internal; sync pin always bit clock (sync sclk_o here toggles only every 8 bits).
// R19: status writes never set flags; read-1 then write-0 clears; two ignore.
// R20: status register resets and enters standby as 0x84.
// R21: tx_buf_empty set by reset, standby, tx disable, or load to shifter.
// R22: rx_buf_full set on clean frame; cleared by reset, r1w0 or dma read.
// R23: rx_buf_full still set at frame end flags overrun and drops data.
// R24: framing error on low first stop bit; data kept, rx_buf_full unset.
// R25: tx_done_flag set at last bit with empty buffer, reset, or tx disable.
// R26: format bit 7 selects async (0) or clocked synchronous (1) mode.
package scc_pkg;
	localparam logic [2:0] SCC_ADDR_FMT = 3'h0;
	localparam logic [2:0] SCC_ADDR_CTRL = 3'h2;
	localparam logic [2:0] SCC_ADDR_TXD = 3'h3;
	localparam logic [2:0] SCC_ADDR_FLAGS = 3'h4;
	localparam logic [2:0] SCC_ADDR_RXD = 3'h5;
	localparam logic [7:0] SCC_FMT_RST = 8'h00;
	localparam logic [7:0] SCC_CTRL_RST = 8'h00;
	localparam logic [7:0] SCC_FLAGS_RST = 8'h84;
	localparam logic [7:0] SCC_TXD_RST = 8'hff;
	localparam logic [7:0] SCC_RXD_RST = 8'h00;
	localparam int F_SYNC = 7;
	localparam int F_CHR = 6;
	localparam int F_PE = 5;
	localparam int F_ODD = 4;
	localparam int F_STOP = 3;
	localparam int F_MP = 2;
	localparam int C_TIE = 7;
	localparam int C_RIE = 6;
	localparam int C_TE = 5;
	localparam int C_RE = 4;
	localparam int C_ADDR_WAIT_GATE = 3;
	localparam int C_TXDONE_IRQ_EN = 2;
	localparam int C_CKE1 = 1;
	localparam int C_CKE0 = 0;
	localparam int S_TX_BUF_EMPTY = 7;
	localparam int S_RX_BUF_FULL = 6;
	localparam int S_OVERRUN_FLAG = 5;
	localparam int S_FER = 4;
	localparam int S_PER = 3;
	localparam int S_TX_DONE_FLAG = 2;
	localparam int S_MPB = 1;
	localparam int S_MPBT = 0;
	localparam logic [5:0] SCC_PRE_MAX = 6'h3f;
	localparam logic [3:0] SCC_OVS_LAST = 4'hf;
	localparam logic [3:0] SCC_OVS_MID = 4'h7;
	localparam logic [3:0] SCC_CNT_DATA8 = 4'h8;
	localparam logic [3:0] SCC_CNT_DATA7 = 4'h7;
	localparam logic [7:0] SCC_BAUD_DEF = 8'hff;
endpackage

// ===== design/scc_prescale.sv
`timescale 1ns/1ps
module scc_prescale (
	input wire logic core_clk_i,
	input wire logic resetn_i,
	input wire logic [1:0] prescale_sel_i,
	output logic tick_o
);
	import scc_pkg::*;
	logic [5:0] div;
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			div <= '0;
		end else begin
			div <= div + 6'h01;
		end
	end
	// R4
	always_comb begin
		case (prescale_sel_i)
			2'h0: tick_o = 1'b1;
			2'h1: tick_o = (div[1:0] == SCC_PRE_MAX[1:0]);
			2'h2: tick_o = (div[3:0] == SCC_PRE_MAX[3:0]);
			default: tick_o = (div == SCC_PRE_MAX);
		endcase
	end
endmodule

// ===== sim/scc_ctrl_status_tb.sv
`timescale 1ns/1ps
module scc_ctrl_status_tb;
	import scc_pkg::*;
	logic clk, resetn, standby, wr, rd, dma_wr, dma_rd, txd, sclk, rxd;
	logic sclk_out, sclk_oe, ti, ri, ei, di;
	logic [2:0] addr;
	logic [7:0] wdata, rdata, dma_data, rv;
	int err_count, n_tests;
	always #12.5 clk = ~clk;
	scc_ctrl_status i_scc_ctrl_status (.core_clk_i(clk), .resetn_i(resetn),
		.standby_i(standby), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
		.rd_i(rd), .rdata_o(rdata), .dma_tx_wr_i(dma_wr),
		.dma_tx_data_i(dma_data), .dma_rx_rd_i(dma_rd), .baud_div_i(8'h00),
		.rxd_i(rxd), .txd_o(txd), .sclk_i(sclk), .sclk_o(sclk_out),
		.sclk_oe_o(sclk_oe), .txempty_irq_o(ti), .rxfull_irq_o(ri),
		.rxerr_irq_o(ei), .txdone_irq_o(di));
	scc_peer i_scc_peer (.txd_i(txd), .sclk_o(sclk), .rxd_o(rxd));
	task stop_test;
		$display("comparisons=%0d mismatches=%0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task check(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task wr_reg(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask
	task rd_chk(input logic [2:0] a, input logic [7:0] exp);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 rv = rdata;
		check(rv, exp);
	endtask
	// polls a flag bit; a flag that never arrives ends the run
	task wait_flag(input int b);
		int i;
		for (i = 0; i < 400; i++) begin
			@(posedge clk);
			addr <= SCC_ADDR_FLAGS;
			rd <= 1'b1;
			@(posedge clk);
			rd <= 1'b0;
			#1 rv = rdata;
			if (rv[b] === 1'b1)
				break;
		end
		if (i == 400) begin
			check(rv, 8'hxx);
			stop_test();
		end
	endtask
	task settle;
		repeat (12) @(posedge clk);
		#1;
	endtask
	task t_reset;
		check({txd, ti, ri, ei, di}, 8'h10);
		rd_chk(SCC_ADDR_FMT, 8'h00);
		rd_chk(SCC_ADDR_CTRL, 8'h00);
		rd_chk(SCC_ADDR_FLAGS, 8'h84);
		rd_chk(SCC_ADDR_TXD, 8'hff);
		rd_chk(SCC_ADDR_RXD, 8'h00);
		rd_chk(3'h1, 8'h00);
		wr_reg(SCC_ADDR_CTRL, 8'h5a);
		rd_chk(SCC_ADDR_CTRL, 8'h5a);
		wr_reg(SCC_ADDR_CTRL, 8'h01);
		check({7'h0, sclk_oe}, 8'h01);
		wr_reg(SCC_ADDR_CTRL, 8'h00);
		check({7'h0, sclk_oe}, 8'h00);
		wr_reg(SCC_ADDR_FMT, 8'h80);
		check({7'h0, sclk_oe}, 8'h01);
		wr_reg(SCC_ADDR_FMT, 8'h00);
		wr_reg(SCC_ADDR_FLAGS, 8'hff);
		rd_chk(SCC_ADDR_FLAGS, 8'h85);
		wr_reg(SCC_ADDR_FLAGS, 8'h00);
		rd_chk(SCC_ADDR_FLAGS, 8'h84);
		wr_reg(SCC_ADDR_CTRL, 8'ha5);
		@(posedge clk);
		standby <= 1'b1;
		repeat (2) @(posedge clk);
		standby <= 1'b0;
		rd_chk(SCC_ADDR_CTRL, 8'h00);
		rd_chk(SCC_ADDR_FLAGS, 8'h84);
	endtask
	// two frames back to back: the idle gap equals the stop length
	task t_tx(input logic stop2);
		i_scc_peer.rx_q.delete();
		wr_reg(SCC_ADDR_FMT, {4'h0, stop2, 3'h0});
		wr_reg(SCC_ADDR_CTRL, 8'ha4);
		check({6'h0, ti, di}, 8'h03);
		wr_reg(SCC_ADDR_TXD, 8'h3c);
		rd_chk(SCC_ADDR_FLAGS, 8'h84);
		wr_reg(SCC_ADDR_FLAGS, 8'h7e);
		check({7'h0, di}, 8'h00);
		wait_flag(S_TX_BUF_EMPTY);
		@(posedge clk);
		dma_data <= 8'hc3;
		dma_wr <= 1'b1;
		@(posedge clk);
		dma_wr <= 1'b0;
		wait_flag(S_TX_DONE_FLAG);
		#1 check({7'h0, di}, 8'h01);
		check(8'(i_scc_peer.rx_q.size()), 8'h02);
		if (i_scc_peer.rx_q.size() == 2) begin
			check(i_scc_peer.rx_q[0], 8'h3c);
			check(i_scc_peer.rx_q[1], 8'hc3);
		end
		check(8'(i_scc_peer.last_gap), {7'h0, stop2} + 8'h01);
		wr_reg(SCC_ADDR_CTRL, 8'h02);
		rd_chk(SCC_ADDR_FLAGS, 8'h84);
	endtask
	task t_rx;
		wr_reg(SCC_ADDR_FMT, 8'h00);
		wr_reg(SCC_ADDR_CTRL, 8'h50);
		i_scc_peer.send_frame(8'ha5, 1'b0, 1'b0, 1'b1);
		settle();
		check({7'h0, ri}, 8'h01);
		rd_chk(SCC_ADDR_FLAGS, 8'hc4);
		rd_chk(SCC_ADDR_RXD, 8'ha5);
		i_scc_peer.send_frame(8'h5a, 1'b0, 1'b0, 1'b1);
		settle();
		check({7'h0, ei}, 8'h01);
		rd_chk(SCC_ADDR_FLAGS, 8'he4);
		rd_chk(SCC_ADDR_RXD, 8'ha5);
		wr_reg(SCC_ADDR_CTRL, 8'h40);
		rd_chk(SCC_ADDR_FLAGS, 8'he4);
		wr_reg(SCC_ADDR_FLAGS, 8'h9e);
		rd_chk(SCC_ADDR_FLAGS, 8'h84);
		check({6'h0, ri, ei}, 8'h00);
		wr_reg(SCC_ADDR_CTRL, 8'h50);
		i_scc_peer.send_frame(8'h11, 1'b0, 1'b0, 1'b0);
		settle();
		rd_chk(SCC_ADDR_FLAGS, 8'h94);
		rd_chk(SCC_ADDR_RXD, 8'h11);
		check({7'h0, ei}, 8'h01);
		wr_reg(SCC_ADDR_FLAGS, 8'hee);
		i_scc_peer.send_frame(8'h22, 1'b0, 1'b0, 1'b1);
		settle();
		rd_chk(SCC_ADDR_FLAGS, 8'hc4);
		@(posedge clk);
		dma_rd <= 1'b1;
		@(posedge clk);
		dma_rd <= 1'b0;
		rd_chk(SCC_ADDR_FLAGS, 8'h84);
	endtask
	task t_mp;
		wr_reg(SCC_ADDR_CTRL, 8'h00);
		wr_reg(SCC_ADDR_FMT, 8'h24);
		wr_reg(SCC_ADDR_CTRL, 8'h58);
		i_scc_peer.send_frame(8'h77, 1'b1, 1'b0, 1'b1);
		settle();
		check({7'h0, ri}, 8'h00);
		rd_chk(SCC_ADDR_FLAGS, 8'h84);
		rd_chk(SCC_ADDR_RXD, 8'h22);
		i_scc_peer.send_frame(8'h99, 1'b1, 1'b1, 1'b1);
		settle();
		rd_chk(SCC_ADDR_FLAGS, 8'hc6);
		rd_chk(SCC_ADDR_CTRL, 8'h50);
		rd_chk(SCC_ADDR_RXD, 8'h99);
	endtask
	initial begin
		clk = 1'b0;
		resetn = 1'b0;
		standby = 1'b0;
		addr = 3'h0;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
		dma_wr = 1'b0;
		dma_rd = 1'b0;
		dma_data = 8'h00;
		err_count = 0;
		n_tests = 0;
		repeat (12) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		#1;
		t_reset();
		// let the baud counter leave its reset count before framing
		repeat (256) @(posedge clk);
		t_tx(1'b0);
		t_tx(1'b1);
		t_rx();
		t_mp();
		stop_test();
	end
	// a hang anywhere ends the run as a mismatch
	initial begin
		#2500000;
		check(8'h00, 8'h01);
		stop_test();
	end
endmodule

// ===== sim/scc_peer.sv
`timescale 1ns/1ps
module scc_peer (
	input wire logic txd_i,
	output logic sclk_o,
	output logic rxd_o
);
	logic [7:0] got;
	logic [3:0] pos;
	logic [7:0] rx_q[$];
	realtime hi_at;
	int last_gap;
	initial begin
		sclk_o = 1'b1;
		rxd_o = 1'b1;
		got = 8'h00;
		pos = 4'h0;
		hi_at = 0.0;
		last_gap = 0;
	end
	// free-running bit clock, 16 core cycles per bit, so no phase lock
	always #200 sclk_o = ~sclk_o;
	// one sample per bit time; phase is arbitrary but never on an edge
	always @(negedge sclk_o) begin
		if (pos == 4'h0) begin
			if (txd_i === 1'b0)
				pos <= 4'h1;
		end else begin
			got <= {txd_i, got[7:1]};
			pos <= (pos == 4'h8) ? 4'h0 : pos + 4'h1;
			if (pos == 4'h8)
				rx_q.push_back({txd_i, got[7:1]});
		end
	end
	// line-high time before each start bit, in whole bit times
	always @(posedge txd_i) hi_at = $realtime;
	always @(negedge txd_i) begin
		if (pos == 4'h0)
			last_gap = $rtoi(($realtime - hi_at + 200.0) / 400.0);
	end
	// lsb first; the line idles high after the frame
	task automatic send_frame(input logic [7:0] d, input logic mp_on,
			input logic mp, input logic stop_ok);
		logic [11:0] bits;
		int n;
		begin
			bits = mp_on ? {1'b1, stop_ok, mp, d, 1'b0} : {2'b11, stop_ok, d, 1'b0};
			n = mp_on ? 12 : 11;
			for (int i = 0; i < n; i++) begin
				@(negedge sclk_o);
				rxd_o = bits[i];
			end
		end
	endtask
endmodule
